// ==== logic/lcd_timing_pkg.sv ====
// Constants and types shared by the LCD clock and frame timing block
package lcd_timing_pkg;
   localparam int unsigned SRC_W        = 2;
   localparam int unsigned DIV_W        = 3;
   localparam int unsigned FRAME_DIVIDER_COUNT_W     = 5;
   localparam int unsigned DUTY_W       = 5;
   localparam int unsigned NSRC         = 4;
   // Frame divider base factor
   localparam int unsigned FRAME_BASE   = 16;
   localparam int unsigned BASE_W       = 4;
   // Reset values of the settings path
   localparam logic [SRC_W-1:0]    SRC_RST  = 2'h0;
   localparam logic [DIV_W-1:0]    DIV_RST  = 3'h0;
   localparam logic [FRAME_DIVIDER_COUNT_W-1:0] FRM_RST  = 5'h00;
   localparam logic [DUTY_W-1:0]   DUTY_RST = 5'h00;
   // Supply gate states
   typedef enum logic [1:0] {
      GATE_RUN  = 2'b01,
      GATE_HALT = 2'b10
   } gate_state_t;
endpackage

// ==== logic/frame_link_if.sv ====
// Carrier between the clock gate and the frame divider
`timescale 1ns/100ps
`default_nettype none
interface frame_link_if;
   import lcd_timing_pkg::*;
   logic                tick;
   logic                running;
   logic [FRAME_DIVIDER_COUNT_W-1:0] frame_count;
   logic [DUTY_W-1:0]   duty;
   logic                frame_pulse;
   logic [8:0]          phase;
   modport gate (output tick, output running, output frame_count,
                 output duty, input frame_pulse, input phase);
   modport div  (input tick, input running, input frame_count,
                 input duty, output frame_pulse, output phase);
endinterface
`default_nettype wire

// ==== logic/frame_divider.sv ====
// Frame divider counting operating-clock ticks into frame pulses
`timescale 1ns/100ps
`default_nettype none
module frame_divider
   import lcd_timing_pkg::*;
(
   input  wire logic clock_i,
   input  wire logic reset_i,
   input  wire logic enable_i,
   frame_link_if.div link
);
   typedef struct packed {
      logic [BASE_W-1:0]   base;
      logic [FRAME_DIVIDER_COUNT_W-1:0] frm;
      logic [DUTY_W-1:0]   duty;
      logic                pulse;
   } div_state_t;

   div_state_t state_reg;
   div_state_t state_next;

   // Nested counters: 16 x (count+1) x (duty+1) ticks per frame
   always_comb begin
      state_next = state_reg;
      state_next.pulse = 1'b0;
      if (!link.running) begin
         state_next.base = '0;
         state_next.frm  = '0;
         state_next.duty = '0;
      end else if (link.tick) begin
         state_next.base = state_reg.base + 4'h1;
         if (state_reg.base == BASE_W'(FRAME_BASE - 1)) begin
            if (state_reg.frm >= link.frame_count) begin
               state_next.frm = '0;
               if (state_reg.duty >= link.duty) begin
                  state_next.duty  = '0;
                  state_next.pulse = 1'b1;
               end else begin
                  state_next.duty = state_reg.duty + 5'h01;
               end
            end else begin
               state_next.frm = state_reg.frm + 5'h01;
            end
         end
      end
   end

   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         state_reg <= '0;
      end else if (enable_i) begin
         state_reg <= state_next;
      end
   end

   assign link.frame_pulse = state_reg.pulse;
   assign link.phase = {state_reg.base, state_reg.frm};
endmodule
`default_nettype wire

// ==== logic/lcd_clock_timing.sv ====
// LCD operating clock supply control and frame rate generation
// Function
// - The operating clock uses a 2-bit source select and 3-bit divider.
// - With debug run 0, entering debug stops the operating clock.
// - The clock supply resumes by itself when debug mode ends.
// - While suspended the driver halts, display off, settings kept.
// - With debug run 1 the clock keeps running through debug mode.
// - Frame is clock divided by 16 x (count+1) x (duty+1).
// - The 5-bit frame count takes all values 0 to 31.
// - The 5-bit duty value plus one is the denominator, zero static.
`timescale 1ns/100ps
`default_nettype none
module lcd_clock_timing
   import lcd_timing_pkg::*;
(
   input  wire logic                clock_i,
   input  wire logic                reset_i,
   input  wire logic                enable_i,
   input  wire logic [NSRC-1:0]     source_ticks_i,
   input  wire logic [NSRC-1:0]     source_running_i,
   input  wire logic [SRC_W-1:0]    clock_source_select_i,
   input  wire logic [DIV_W-1:0]    clock_divider_select_i,
   input  wire logic                debug_run_i,
   input  wire logic                cpu_debug_i,
   input  wire logic [FRAME_DIVIDER_COUNT_W-1:0] frame_divider_count_i,
   input  wire logic [DUTY_W-1:0]   drive_duty_select_i,
   output logic                     lcd_core_clock_o,
   output logic                     clock_active_o,
   output logic                     display_on_o,
   output logic                     frame_pulse_o,
   output logic                     frame_signal_o
);
   typedef struct packed {
      logic [NSRC-1:0]      tick_s1;
      logic [NSRC-1:0]      tick_s2;
      logic [NSRC-1:0]      tick_s3;
      logic [NSRC-1:0]      run_s1;
      logic [NSRC-1:0]      run_s2;
      logic                 dbg_s1;
      logic                 dbg_s2;
      logic [6:0]           prediv;
      gate_state_t          gate;
      logic                 core_tick;
      logic                 core_clk;
      logic                 active;
      logic                 display;
      logic                 frame_pulse;
      logic                 frame_sig;
   } top_state_t;

   top_state_t state_reg;
   top_state_t state_next;
   frame_link_if link ();

   logic src_edge;
   logic src_run;
   logic div_hit;

   frame_divider u_div (
      .clock_i  (clock_i),
      .reset_i  (reset_i),
      .enable_i (enable_i),
      .link     (link)
   );

   // Rising edges of the selected source, from synchronised copies
   // source select
   assign src_edge = state_reg.tick_s2[clock_source_select_i] &
                     ~state_reg.tick_s3[clock_source_select_i];
   assign src_run  = state_reg.run_s2[clock_source_select_i];
   // Divide by 2^select; prediv bit marks the ratio boundary
   // division ratio
   assign div_hit = (clock_divider_select_i == DIV_RST) ? 1'b1 :
      (state_reg.prediv[clock_divider_select_i - 3'h1] &
       ~(|(state_reg.prediv & ((7'h01 << (clock_divider_select_i
        - 3'h1)) - 7'h01))));

   // Feed the divider only while the supply gate is open
   assign link.tick        = state_next.core_tick;
   assign link.running     = state_reg.active;
   assign link.frame_count = frame_divider_count_i;
   assign link.duty        = drive_duty_select_i;

   always_comb begin
      state_next = state_reg;
      state_next.tick_s1 = source_ticks_i;
      state_next.tick_s2 = state_reg.tick_s1;
      state_next.tick_s3 = state_reg.tick_s2;
      state_next.run_s1  = source_running_i;
      state_next.run_s2  = state_reg.run_s1;
      state_next.dbg_s1  = cpu_debug_i;
      state_next.dbg_s2  = state_reg.dbg_s1;
      state_next.core_tick = 1'b0;
      unique case (state_reg.gate)
         GATE_RUN: begin
            if (state_reg.dbg_s2 && !debug_run_i) begin
               state_next.gate = GATE_HALT;
            end
         end
         GATE_HALT: begin
            if (!state_reg.dbg_s2 || debug_run_i) begin
               state_next.gate = GATE_RUN;
            end
         end
         default: state_next.gate = GATE_RUN;
      endcase
      // Prescaler only advances on source edges while supplied
      if (state_reg.gate == GATE_RUN && src_run) begin
         if (src_edge) begin
            state_next.prediv = state_reg.prediv + 7'h01;
            if (div_hit) begin
               state_next.core_tick = 1'b1;
               state_next.core_clk  = ~state_reg.core_clk;
            end
         end
      end else begin
         // halt holds settings, only timing state parks
         state_next.prediv   = '0;
         state_next.core_clk = 1'b0;
      end
      state_next.active  = (state_reg.gate == GATE_RUN) && src_run;
      state_next.display = state_next.active;
      state_next.frame_pulse = link.frame_pulse;
      if (!state_reg.active) begin
         state_next.frame_sig = 1'b0;
      end else if (link.frame_pulse) begin
         state_next.frame_sig = ~state_reg.frame_sig;
      end
   end

   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         state_reg      <= '0;
         state_reg.gate <= GATE_RUN;
      end else if (enable_i) begin
         state_reg <= state_next;
      end
   end

   // All outputs straight from flip-flops
   assign lcd_core_clock_o = state_reg.core_clk;
   assign clock_active_o   = state_reg.active;
   assign display_on_o     = state_reg.display;
   assign frame_pulse_o    = state_reg.frame_pulse;
   assign frame_signal_o   = state_reg.frame_sig;
endmodule
`default_nettype wire

// ==== tb/lcd_clock_timing_chk.sv ====
// Port checker for the LCD clock and frame timing block
`timescale 1ns/100ps
`default_nettype none
module lcd_clock_timing_chk
   import lcd_timing_pkg::*;
(
   input wire logic            clock_i,
   input wire logic            reset_i,
   input wire logic            enable_i,
   input wire logic [NSRC-1:0] source_running_i,
   input wire logic            debug_run_i,
   input wire logic            cpu_debug_i,
   input wire logic            lcd_core_clock_o,
   input wire logic            clock_active_o,
   input wire logic            display_on_o,
   input wire logic            frame_pulse_o,
   input wire logic            frame_signal_o
);
   default clocking @(posedge clock_i); endclocking
   default disable iff (reset_i);
   // Held long enough to cover the input synchronisers
   sequence halt_s;
      (cpu_debug_i && !debug_run_i)[*8];
   endsequence
   sequence keep_s;
      (debug_run_i && enable_i && &source_running_i)[*8];
   endsequence
   AST_STOP: assert property (halt_s |-> !clock_active_o)
      else $error("supply still active in debug");
   AST_RUN: assert property (keep_s |-> clock_active_o)
      else $error("supply stopped with run bit set");
   AST_DISP: assert property (display_on_o == clock_active_o)
      else $error("display state differs from supply");
   AST_HALT: assert property (!clock_active_o |=> !frame_signal_o)
      else $error("frame signal alive while halted");
   AST_ONE: assert property (frame_pulse_o |=> !frame_pulse_o)
      else $error("frame pulse longer than one cycle");
   AST_TOG: assert property (frame_pulse_o |-> $changed(frame_signal_o))
      else $error("frame signal did not toggle");
   AST_HOLD: assert property ($changed(frame_signal_o) && clock_active_o
      |-> frame_pulse_o)
      else $error("frame signal moved without a frame");
   AST_FROZE: assert property (!clock_active_o[*3]
      |-> $stable(lcd_core_clock_o))
      else $error("core clock moved while halted");
endmodule
bind lcd_clock_timing lcd_clock_timing_chk u_chk (.clock_i, .reset_i,
   .enable_i, .source_running_i, .debug_run_i, .cpu_debug_i,
   .lcd_core_clock_o, .clock_active_o, .display_on_o, .frame_pulse_o,
   .frame_signal_o);
`default_nettype wire

// ==== tb/clock_gen_model.sv ====
// Clock generator model with four startable oscillators
`timescale 1ns/100ps
`default_nettype none
module clock_gen_model (
   input  wire logic       clock_i,
   input  wire logic [3:0] start_i,
   output logic      [3:0] ticks_o,
   output logic      [3:0] running_o
);
   int t = 0;
   initial begin
      ticks_o = 4'h0;
      running_o = 4'h0;
   end
   // a source runs only while its start bit is held and is never halted by sleep
   // Rates scaled far above 32 kHz, distinct per source to expose
   // a wrong selection
   always @(posedge clock_i) begin
      t <= t + 1;
      running_o <= start_i;
      for (int k = 0; k < 4; k++)
         if (start_i[k]) ticks_o[k] <= 1'((t / (k + 2)) % 2);
   end
endmodule
`default_nettype wire

// ==== tb/lcd_clock_timing_tb.sv ====
// Self-checking bench for the LCD clock and frame timing block
`timescale 1ns/100ps
`default_nettype none
module lcd_clock_timing_tb;
   import lcd_timing_pkg::*;
   logic             clock_i = 0, reset_i = 1;
   logic             debug_run_i = 0, cpu_debug_i = 0;
   logic [3:0]       ticks, running;
   logic [SRC_W-1:0] src = 0;
   logic [DIV_W-1:0] div = 0;
   logic [4:0]       frm = 0, duty = 0;
   logic             core, act, disp, pulse, fsig, core_q, tick_q;
   int               fail_count = 0, checks_done = 0, cyc = 0, tog, rise;
   always #4 clock_i = ~clock_i;
   clock_gen_model u_clock_gen_model (.clock_i, .start_i(4'hF),
      .ticks_o(ticks), .running_o(running));
   lcd_clock_timing u_lcd_clock_timing (.clock_i, .reset_i,
      .enable_i(1'b1), .source_ticks_i(ticks), .source_running_i(running),
      .clock_source_select_i(src), .clock_divider_select_i(div),
      .debug_run_i, .cpu_debug_i, .frame_divider_count_i(frm),
      .drive_duty_select_i(duty), .lcd_core_clock_o(core),
      .clock_active_o(act), .display_on_o(disp), .frame_pulse_o(pulse),
      .frame_signal_o(fsig));
   // Edge counters; the cycle ceiling cuts a hang short
   always @(posedge clock_i) begin
      core_q <= core;
      tick_q <= ticks[src];
      tog <= tog + int'(core != core_q);
      rise <= rise + int'(ticks[src] && !tick_q);
      cyc <= cyc + 1;
      if (cyc == 90000) begin
         fail_count++;
         end_sim();
      end
   end
   function automatic logic [15:0] frame_ticks(input logic [4:0] f, d);
      return 16'(16 * (f + 1) * (d + 1));
   endfunction
   task automatic chk(input logic [15:0] got, exp);
      checks_done++;
      if (got !== exp) begin
         fail_count++;
         $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask
   task automatic wait_frame();
      while (pulse !== 1'b1) begin
         @(posedge clock_i);
         #1;
      end
      @(posedge clock_i);
      #1;
   endtask
   // Settle two frames after a change, then measure one whole frame
   task automatic run_case(input logic [4:0] f, d, input logic [2:0] v,
                           input logic [1:0] s);
      src = s;
      div = v;
      frm = f;
      duty = d;
      wait_frame();
      wait_frame();
      tog = 0;
      rise = 0;
      wait_frame();
      chk(16'(tog), frame_ticks(f, d));
      chk(16'(rise), frame_ticks(f, d) << v);
   endtask
   task automatic end_sim();
      if (fail_count == 0 && checks_done > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   initial begin
      logic [31:0] r;
      r = $urandom(32);
      repeat (12) @(posedge clock_i);
      #1 reset_i = 0;
      run_case(5'h1F, 5'h00, 3'h0, 2'h0);
      run_case(5'h00, 5'h1F, 3'h0, 2'h1);
      for (int i = 0; i < 5; i++) begin
         r = $urandom;
         // Duty kept small so the whole run stays under the ceiling
         run_case({3'h0, r[1:0]}, {4'h0, r[2]}, {2'h0, r[4]}, r[6:5]);
      end
      // Debug with the run bit clear halts supply and display
      cpu_debug_i = 1;
      repeat (8) @(posedge clock_i);
      #1 chk({13'h0, act, disp, fsig}, 16'h0);
      cpu_debug_i = 0;
      run_case(frm, duty, div, src);
      chk({15'h0, act}, 16'h1);
      // Run bit set keeps frames going through debug
      debug_run_i = 1;
      cpu_debug_i = 1;
      run_case(frm, duty, div, src);
      chk({14'h0, act, disp}, 16'h3);
      end_sim();
   end
endmodule
`default_nettype wire
